// file: include/mlz_pkg.sv
`default_nettype none
package mlz_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MAX_VEL = 8'h04;
   localparam logic [7:0] OFF_MAX_ACC = 8'h08;
   localparam logic [7:0] OFF_PEAK_CUR = 8'h0C;
   localparam logic [7:0] OFF_CONT_CUR = 8'h10;
   localparam logic [7:0] OFF_PEAK_DUR = 8'h14;
   localparam logic [7:0] OFF_HOLD_PCT = 8'h18;
   localparam logic [7:0] OFF_SW_POS = 8'h1C;
   localparam logic [7:0] OFF_SW_NEG = 8'h20;
   localparam logic [7:0] OFF_ZONE_POS = 8'h24;
   localparam logic [7:0] OFF_ZONE_NEG = 8'h28;
   localparam logic [7:0] OFF_INPOS = 8'h2C;
   localparam logic [7:0] OFF_PERR = 8'h30;
   localparam logic [7:0] OFF_STROKE = 8'h34;
   localparam logic [7:0] OFF_HOME_OFS = 8'h38;
   localparam logic [7:0] OFF_DRV_MAX = 8'h3C;
   localparam logic [7:0] OFF_STATUS = 8'h40;
   localparam logic [7:0] OFF_CMD_VEL = 8'h44;
   localparam logic [7:0] OFF_CMD_ACC = 8'h48;
   localparam logic [7:0] OFF_CUR_CMD = 8'h4C;
   localparam logic [7:0] OFF_GAIN = 8'h50;
   localparam logic [7:0] OFF_OVL_ACC = 8'h54;
   // ctrl field positions
   localparam int CTRL_ECO = 0;
   localparam int CTRL_LOAD_DEF = 1;
   localparam int CTRL_HM_LSB = 2;
   localparam int CTRL_HDIR_POS = 4;
   // status field positions
   localparam int ST_ZONE = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_PERR = 2;
   localparam int ST_OVL = 3;
   localparam int ST_HOLD = 4;
   localparam int ST_ECO_IDLE = 5;
   // reset values
   localparam logic [31:0] RST_MAX_VEL = 32'h0000_0000;
   localparam logic [31:0] RST_MAX_ACC = 32'h0000_0000;
   localparam logic [31:0] RST_CUR = 32'h0000_0000;
   localparam logic [31:0] RST_PEAK_DUR = 32'h0000_0064;
   localparam logic [31:0] RST_HOLD_PCT = 32'h0000_0064;
   localparam logic [31:0] RST_POS_LIM = 32'h7FFF_FFFF;
   localparam logic [31:0] RST_NEG_LIM = 32'h8000_0000;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] ACC_VEL_RATIO = 32'h0000_0028;
   localparam logic [31:0] PCT_FULL = 32'h0000_0064;
   // one millisecond of pclk at 100 MHz for the overload tick
   localparam int CLK_HZ = 100_000_000;
   localparam int OVL_TICK_US = 1000;
   localparam int OVL_TICK_CYC = CLK_HZ / 1_000_000 * OVL_TICK_US;

   typedef enum {HM_HARD_STOP, HM_LIMIT_SW, HM_INDEX} mlz_home_type;
   typedef enum {MS_IDLE, MS_MOVE, MS_HOME, MS_STOP} mlz_state_type;

   typedef struct packed {
      logic start;            // move start pulse
      logic home;             // homing move
      logic signed [31:0] target;
      logic [31:0] vel;
      logic [31:0] acc;
      logic [6:0] force_pct;
   } mlz_cmd_type;

   typedef struct packed {
      logic signed [31:0] actual;
      logic signed [31:0] commanded;
      logic [15:0] current;   // measured motor current
      logic done;             // profile finished
   } mlz_fb_type;
endpackage
`default_nettype wire

// file: hdl/mlz_supervisor.sv
`default_nettype none
module mlz_supervisor
(
   input wire logic pclk,                    // clock
   input wire logic presetn,                 // async reset, low
   input wire logic psel,                    // apb select
   input wire logic penable,                 // apb enable
   input wire logic pwrite,                  // apb direction
   input wire logic [7:0] paddr,             // apb byte address
   input wire logic [31:0] pwdata,           // apb write data
   output logic [31:0] prdata,               // apb read data
   output logic pready,                      // apb ready
   output logic pslverr,                     // apb error
   input wire mlz_pkg::mlz_cmd_type cmd,     // move request
   input wire mlz_pkg::mlz_fb_type fb,       // feedback
   input wire logic lim_sw_pos,              // positive limit switch
   input wire logic lim_sw_neg,              // negative limit switch
   input wire logic fault_stop,              // safety stop request
   output logic move_start,                  // accepted move pulse
   output logic signed [31:0] move_target,   // accepted target
   output logic [31:0] move_vel,             // clamped velocity
   output logic [31:0] move_acc,             // clamped accel/decel
   output logic [15:0] current_limit,        // current ceiling
   output logic [7:0] loop_gain_pct,         // loop gain percent
   output logic loop_hold,                   // correction suspended
   output logic zone_out,                    // position window output
   output logic lim_sw_pos_eff,              // gated limit switch
   output logic lim_sw_neg_eff,              // gated limit switch
   output logic pos_err_fault,               // position error fault
   output logic overload_fault               // overload fault
);
   import mlz_pkg::*;

   logic [31:0] ctrl;
   logic [31:0] max_vel, max_acc, peak_cur, cont_cur, peak_dur, hold_pct;
   logic signed [31:0] sw_pos, sw_neg, zone_pos, zone_neg;
   logic [31:0] inpos, perr_lim, stroke, home_ofs, drv_max;
   logic refused;
   mlz_state_type state;
   logic [31:0] ovl_acc;
   logic [$clog2(OVL_TICK_CYC)-1:0] tick_cnt;
   logic tick;

   wire logic wr_en = psel & penable & pwrite;
   wire logic [1:0] hm = ctrl[CTRL_HM_LSB +: 2];
   wire logic home_dir_pos = ctrl[CTRL_HDIR_POS];
   wire logic eco_en = ctrl[CTRL_ECO];

   // accel ceiling is the smaller of setting and forty times velocity
   logic [31:0] acc_cap;
   logic [63:0] acc_vel_prod;
   always_comb begin
      acc_vel_prod = max_vel * ACC_VEL_RATIO;
      acc_cap = max_acc;
      if (acc_vel_prod < {32'h0000_0000, max_acc}) begin
         acc_cap = acc_vel_prod[31:0];
      end
   end

   // default limits from homing method
   logic signed [31:0] def_pos, def_neg;
   always_comb begin
      def_pos = $signed(stroke);
      def_neg = -$signed(stroke);
      if (hm == 2'(HM_HARD_STOP)) begin
         if (home_dir_pos) begin
            def_pos = $signed(home_ofs);
            def_neg = $signed(home_ofs) - $signed(stroke);
         end else begin
            def_pos = $signed(stroke) - $signed(home_ofs);
            def_neg = -$signed(home_ofs);
         end
      end else if (hm == 2'(HM_INDEX)) begin
         def_pos = $signed(drv_max);
         def_neg = -$signed(drv_max);
      end
   end

   // apb register writes; load_def is a self-clearing action
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= RST_ZERO;
         max_vel <= RST_MAX_VEL;
         max_acc <= RST_MAX_ACC;
         peak_cur <= RST_CUR;
         cont_cur <= RST_CUR;
         peak_dur <= RST_PEAK_DUR;
         hold_pct <= RST_HOLD_PCT;
         sw_pos <= RST_POS_LIM;
         sw_neg <= RST_NEG_LIM;
         zone_pos <= RST_ZERO;
         zone_neg <= RST_ZERO;
         inpos <= RST_ZERO;
         perr_lim <= RST_ZERO;
         stroke <= RST_ZERO;
         home_ofs <= RST_ZERO;
         drv_max <= RST_ZERO;
      end else begin
         ctrl[CTRL_LOAD_DEF] <= 1'b0;
         if (ctrl[CTRL_LOAD_DEF]) begin
            sw_pos <= def_pos;
            sw_neg <= def_neg;
         end
         if (wr_en) begin
            if (paddr == OFF_CTRL) begin
               ctrl <= pwdata;
            end else if (paddr == OFF_MAX_VEL) begin
               max_vel <= pwdata;
            end else if (paddr == OFF_MAX_ACC) begin
               max_acc <= pwdata;
            end else if (paddr == OFF_PEAK_CUR) begin
               peak_cur <= pwdata;
            end else if (paddr == OFF_CONT_CUR) begin
               cont_cur <= pwdata;
            end else if (paddr == OFF_PEAK_DUR) begin
               peak_dur <= pwdata;
            end else if (paddr == OFF_HOLD_PCT) begin
               hold_pct <= pwdata;
            end else if (paddr == OFF_SW_POS) begin
               sw_pos <= pwdata;
            end else if (paddr == OFF_SW_NEG) begin
               sw_neg <= pwdata;
            end else if (paddr == OFF_ZONE_POS) begin
               zone_pos <= pwdata;
            end else if (paddr == OFF_ZONE_NEG) begin
               zone_neg <= pwdata;
            end else if (paddr == OFF_INPOS) begin
               inpos <= pwdata;
            end else if (paddr == OFF_PERR) begin
               perr_lim <= pwdata;
            end else if (paddr == OFF_STROKE) begin
               stroke <= pwdata;
            end else if (paddr == OFF_HOME_OFS) begin
               home_ofs <= pwdata;
            end else if (paddr == OFF_DRV_MAX) begin
               drv_max <= pwdata;
            end
         end
      end
   end

   // apb answer: zero wait, unmapped returns slverr
   logic mapped;
   logic [31:0] rd_mux;
   always_comb begin
      mapped = 1'b1;
      rd_mux = RST_ZERO;
      if (paddr == OFF_CTRL) begin
         rd_mux = ctrl;
      end else if (paddr == OFF_MAX_VEL) begin
         rd_mux = max_vel;
      end else if (paddr == OFF_MAX_ACC) begin
         rd_mux = max_acc;
      end else if (paddr == OFF_PEAK_CUR) begin
         rd_mux = peak_cur;
      end else if (paddr == OFF_CONT_CUR) begin
         rd_mux = cont_cur;
      end else if (paddr == OFF_PEAK_DUR) begin
         rd_mux = peak_dur;
      end else if (paddr == OFF_HOLD_PCT) begin
         rd_mux = hold_pct;
      end else if (paddr == OFF_SW_POS) begin
         rd_mux = sw_pos;
      end else if (paddr == OFF_SW_NEG) begin
         rd_mux = sw_neg;
      end else if (paddr == OFF_ZONE_POS) begin
         rd_mux = zone_pos;
      end else if (paddr == OFF_ZONE_NEG) begin
         rd_mux = zone_neg;
      end else if (paddr == OFF_INPOS) begin
         rd_mux = inpos;
      end else if (paddr == OFF_PERR) begin
         rd_mux = perr_lim;
      end else if (paddr == OFF_STROKE) begin
         rd_mux = stroke;
      end else if (paddr == OFF_HOME_OFS) begin
         rd_mux = home_ofs;
      end else if (paddr == OFF_DRV_MAX) begin
         rd_mux = drv_max;
      end else if (paddr == OFF_STATUS) begin
         rd_mux = {26'h0, loop_hold, current_limit != 16'h0000 &&
                   state == MS_IDLE, overload_fault, pos_err_fault,
                   refused, zone_out};
      end else if (paddr == OFF_CMD_VEL) begin
         rd_mux = move_vel;
      end else if (paddr == OFF_CMD_ACC) begin
         rd_mux = move_acc;
      end else if (paddr == OFF_CUR_CMD) begin
         rd_mux = {16'h0000, current_limit};
      end else if (paddr == OFF_GAIN) begin
         rd_mux = {24'h00_0000, loop_gain_pct};
      end else if (paddr == OFF_OVL_ACC) begin
         rd_mux = ovl_acc;
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= RST_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata <= (psel & ~penable & ~pwrite) ? rd_mux : RST_ZERO;
      end
   end

   // signed comparisons every cycle; zone never gates motion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zone_out <= 1'b0;
      end else begin
         zone_out <= (fb.actual >= zone_neg) && (fb.actual < zone_pos);
      end
   end

   // hard-stop homing masks both switches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lim_sw_pos_eff <= 1'b0;
         lim_sw_neg_eff <= 1'b0;
      end else begin
         lim_sw_pos_eff <= lim_sw_pos & ~(state == MS_HOME &&
                           hm == 2'(HM_HARD_STOP));
         lim_sw_neg_eff <= lim_sw_neg & ~(state == MS_HOME &&
                           hm == 2'(HM_HARD_STOP));
      end
   end

   // command acceptance and motion state
   wire logic out_of_lim = (cmd.target > sw_pos) || (cmd.target < sw_neg);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= MS_IDLE;
         move_start <= 1'b0;
         move_target <= RST_ZERO;
         move_vel <= RST_ZERO;
         move_acc <= RST_ZERO;
         refused <= 1'b0;
      end else begin
         move_start <= 1'b0;
         if (wr_en && paddr == OFF_STATUS && pwdata[ST_REFUSED]) begin
            refused <= 1'b0;
         end
         case (state)
            MS_IDLE, MS_MOVE, MS_HOME: begin
               if (fault_stop && state != MS_IDLE) begin
                  state <= MS_STOP;
                  move_acc <= acc_cap;
               end else if (cmd.start && !fault_stop) begin
                  if (!cmd.home && out_of_lim) begin
                     refused <= 1'b1;
                  end else begin
                     // homing skips the limit test entirely
                     state <= cmd.home ? MS_HOME : MS_MOVE;
                     move_start <= 1'b1;
                     move_target <= cmd.target;
                     move_vel <= (cmd.vel > max_vel) ? max_vel : cmd.vel;
                     move_acc <= (cmd.acc > acc_cap) ? acc_cap : cmd.acc;
                  end
               end else if (fb.done) begin
                  state <= MS_IDLE;
               end
            end
            MS_STOP: begin
               if (fb.done) begin
                  state <= MS_IDLE;
               end
            end
            default: state <= MS_IDLE;
         endcase
      end
   end

   // current ceiling: force of peak while moving, capped at continuous on overload, holding when idle
   logic [15:0] force_cur;
   logic [47:0] force_prod;
   logic [15:0] hold_cur;
   logic [47:0] hold_prod;
   logic [31:0] force_pct_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_pct_r <= PCT_FULL;
      end else if (cmd.start) begin
         force_pct_r <= {25'h0, cmd.force_pct};
      end
   end
   always_comb begin
      force_prod = {16'h0000, peak_cur} * {16'h0000, force_pct_r};
      force_cur = 16'(force_prod / 48'(PCT_FULL));
      hold_prod = {16'h0000, peak_cur} * {16'h0000, hold_pct};
      hold_cur = 16'(hold_prod / 48'(PCT_FULL));
   end

   // overload: squared current minus continuous squared, per tick
   logic [31:0] cur_sq, cont_sq, peak_sq;
   logic [63:0] ovl_budget;
   always_comb begin
      cur_sq = {16'h0000, fb.current} * {16'h0000, fb.current};
      cont_sq = cont_cur[15:0] * cont_cur[15:0];
      peak_sq = peak_cur[15:0] * peak_cur[15:0];
      ovl_budget = 64'((peak_sq - cont_sq)) * {32'h0, peak_dur};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (tick_cnt == ($clog2(OVL_TICK_CYC))'(OVL_TICK_CYC - 1));
         if (tick_cnt == ($clog2(OVL_TICK_CYC))'(OVL_TICK_CYC - 1)) begin
            tick_cnt <= '0;
         end else begin
            tick_cnt <= tick_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovl_acc <= RST_ZERO;
         overload_fault <= 1'b0;
      end else begin
         if (tick) begin
            if (cur_sq > cont_sq) begin
               ovl_acc <= ovl_acc + (cur_sq - cont_sq);
            end else if (ovl_acc > (cont_sq - cur_sq)) begin
               ovl_acc <= ovl_acc - (cont_sq - cur_sq);
            end else begin
               ovl_acc <= RST_ZERO;
            end
         end
         // set wins over software clear
         if ({32'h0, ovl_acc} > ovl_budget) begin
            overload_fault <= 1'b1;
         end else if (wr_en && paddr == OFF_STATUS && pwdata[ST_OVL]) begin
            overload_fault <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_limit <= 16'h0000;
      end else if (state == MS_IDLE) begin
         current_limit <= hold_cur;
      end else if (overload_fault && force_cur > cont_cur[15:0]) begin
         current_limit <= cont_cur[15:0];
      end else begin
         current_limit <= force_cur;
      end
   end

   // position error and eco gain
   logic signed [32:0] perr;
   logic [32:0] perr_abs;
   logic [47:0] gain_prod;
   logic in_band, moving;
   always_comb begin
      perr = 33'(fb.commanded) - 33'(fb.actual);
      perr_abs = perr[32] ? 33'(-perr) : 33'(perr);
      in_band = perr_abs <= {1'b0, inpos};
      moving = state != MS_IDLE;
      gain_prod = 48'(perr_abs) * 48'(PCT_FULL);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_err_fault <= 1'b0;
      end else if (moving && perr_abs > {1'b0, perr_lim}) begin
         pos_err_fault <= 1'b1;
      end else if (wr_en && paddr == OFF_STATUS && pwdata[ST_PERR]) begin
         pos_err_fault <= 1'b0;
      end
   end

   // gain rises linearly with error, full at the error limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_gain_pct <= 8'h64;
         loop_hold <= 1'b0;
      end else if (eco_en && !moving) begin
         loop_hold <= in_band;
         if (in_band) begin
            loop_gain_pct <= 8'h00;
         end else if (perr_abs >= {1'b0, perr_lim}) begin
            loop_gain_pct <= 8'(PCT_FULL);
         end else begin
            loop_gain_pct <= 8'(gain_prod / 48'(perr_lim));
         end
      end else begin
         loop_hold <= 1'b0;
         loop_gain_pct <= 8'(PCT_FULL);
      end
   end
endmodule
`default_nettype wire

// file: test/mlz_properties.sv
`default_nettype none
module mlz_properties (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [7:0] paddr, // apb
   input wire logic [31:0] pwdata, // apb
   input wire logic [31:0] prdata, // apb
   input wire logic pready, // apb
   input wire logic pslverr, // apb
   input wire mlz_pkg::mlz_cmd_type cmd, // request
   input wire mlz_pkg::mlz_fb_type fb, // feedback
   input wire logic fault_stop, // stop
   input wire logic move_start, // pulse
   input wire logic signed [31:0] move_target, // target
   input wire logic [31:0] move_vel, // velocity
   input wire logic [31:0] move_acc, // accel
   input wire logic zone_out // zone
);
   import mlz_pkg::*;
   logic [31:0] vmax, amax, d;
   logic signed [31:0] swp, swn, zp, zn;
   logic [63:0] v40, cap;
   logic inwin;
   // reads resync copies after default loads
   assign d = pwrite ? pwdata : prdata;
   assign v40 = 64'(vmax) * 64'd40;
   assign cap = (64'(amax) < v40) ? 64'(amax) : v40;
   assign inwin = fb.actual >= zn && fb.actual < zp;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vmax <= RST_MAX_VEL;
         amax <= RST_MAX_ACC;
         swp <= RST_POS_LIM;
         swn <= RST_NEG_LIM;
         zp <= RST_ZERO;
         zn <= RST_ZERO;
      end else if (psel && penable && pready && !pslverr) begin
         case (paddr)
            OFF_MAX_VEL: vmax <= d;
            OFF_MAX_ACC: amax <= d;
            OFF_SW_POS: swp <= d;
            OFF_SW_NEG: swn <= d;
            OFF_ZONE_POS: zp <= d;
            OFF_ZONE_NEG: zn <= d;
            default: ;
         endcase
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_stop;
      $rose(fault_stop);
   endsequence
   a_ready_setup: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_start_cause: assert property (move_start |->
      $past(cmd.start) && !$past(fault_stop))
      else $error("start without request");
   a_vel_clamp: assert property (
      move_start |-> move_vel <= $past(vmax)) else $error("velocity high");
   a_acc_clamp: assert property (
      move_start |-> 64'(move_acc) <= $past(cap))
      else $error("accel high");
   a_target_limits: assert property (
      move_start |-> $past(cmd.home) ||
      (move_target <= $past(swp) && move_target >= $past(swn)))
      else $error("target beyond limits");
   a_zone_window: assert property (
      zone_out == $past(inwin)) else $error("zone mismatch");
   a_stop_decel: assert property (
      s_stop |-> ##[1:3] 64'(move_acc) == cap)
      else $error("stop decel not max");
endmodule
bind mlz_supervisor mlz_properties i_mlz_properties (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .cmd, .fb, .fault_stop, .move_start, .move_target,
   .move_vel, .move_acc, .zone_out);
`default_nettype wire

// file: test/mlz_motor_model.sv
`default_nettype none
module mlz_motor_model (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic move_start, // accepted move
   input wire logic signed [31:0] move_target, // target
   input wire logic [15:0] current_limit, // ceiling
   input wire logic signed [31:0] push, // load disturbance
   output var mlz_pkg::mlz_fb_type fb // feedback
);
   import mlz_pkg::*;
   logic signed [31:0] pos, tgt;
   // one count per cycle: slow enough to catch mid-move states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos <= 32'sh0000_0000;
         tgt <= 32'sh0000_0000;
      end else if (move_start) begin
         tgt <= move_target;
      end else if (pos < tgt) begin
         pos <= pos + 32'sh0000_0001;
      end else if (pos > tgt) begin
         pos <= pos - 32'sh0000_0001;
      end
   end
   assign fb.commanded = pos;
   assign fb.actual = pos + push;
   assign fb.current = current_limit;
   assign fb.done = pos == tgt && !move_start;
endmodule
`default_nettype wire

// file: test/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mlz_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic lim_p, lim_n, fault_stop, move_start, loop_hold, zone_out;
   logic pos_err_fault, eff_p, eff_n;
   logic [7:0] paddr, loop_gain_pct;
   logic [31:0] pwdata, prdata, move_vel, move_acc, q;
   logic signed [31:0] move_target, push;
   logic [15:0] current_limit;
   mlz_cmd_type cmd;
   mlz_fb_type fb;
   int fails = 0, cmp_count = 0;
   mlz_supervisor i_mlz_supervisor (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmd(cmd), .fb(fb), .lim_sw_pos(lim_p),
      .lim_sw_neg(lim_n), .fault_stop(fault_stop),
      .move_start(move_start), .move_target(move_target),
      .move_vel(move_vel), .move_acc(move_acc),
      .current_limit(current_limit), .loop_gain_pct(loop_gain_pct),
      .loop_hold(loop_hold), .zone_out(zone_out), .lim_sw_pos_eff(eff_p),
      .lim_sw_neg_eff(eff_n), .pos_err_fault(pos_err_fault),
      .overload_fault());
   mlz_motor_model i_mlz_motor_model (.pclk(pclk), .presetn(presetn),
      .move_start(move_start), .move_target(move_target),
      .current_limit(current_limit), .push(push), .fb(fb));
   always #5 pclk = ~pclk;
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   // q and error flag taken at ready; one idle edge after
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic e;
      apb(1'b0, a, 32'h0000_0000, e);
      chk(q, x);
   endtask
   task automatic go(input logic h, input logic signed [31:0] t,
         input logic [31:0] v, input logic [31:0] ac);
      cmd <= '{1'b1, h, t, v, ac, 7'd50};
      @(posedge pclk);
      cmd.start <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic settle(input int c);
      int n = 0;
      while (fb.done !== 1'b1 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      if (n == 5000) fails++;
      repeat (c) @(posedge pclk);
   endtask
   task automatic t_regs;
      logic e;
      rd(OFF_MAX_VEL, RST_MAX_VEL);
      rd(OFF_PEAK_DUR, RST_PEAK_DUR);
      rd(OFF_HOLD_PCT, RST_HOLD_PCT);
      rd(OFF_SW_POS, RST_POS_LIM);
      rd(OFF_SW_NEG, RST_NEG_LIM);
      apb(1'b0, 8'hFC, 32'h0000_0000, e);
      chk({31'h0, e}, 32'h0000_0001);
      $display("regs done");
   endtask
   task automatic t_zone;
      logic signed [31:0] p[4] = '{-101, -100, 99, 100};
      logic x[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      wr(OFF_ZONE_NEG, -32'sd100);
      wr(OFF_ZONE_POS, 32'sd100);
      for (int i = 0; i < 4; i++) begin
         push <= p[i];
         repeat (3) @(posedge pclk);
         chk({31'h0, zone_out}, {31'h0, x[i]});
      end
      push <= 32'sh0000_0000;
      $display("zone done");
   endtask
   task automatic t_clamp;
      wr(OFF_MAX_VEL, 32'h0000_000A);
      wr(OFF_MAX_ACC, 32'h0000_03E8);
      go(1'b0, 0, 32'h0000_0032, 32'h0000_0384);
      chk(move_vel, 32'h0000_000A);
      chk(move_acc, 32'h0000_0190);
      wr(OFF_MAX_ACC, 32'h0000_0064);
      go(1'b0, 0, 32'h0000_0005, 32'h0000_00C8);
      chk(move_vel, 32'h0000_0005);
      chk(move_acc, 32'h0000_0064);
      $display("clamp done");
   endtask
   task automatic t_limits;
      wr(OFF_SW_POS, 32'sd1000);
      wr(OFF_SW_NEG, -32'sd1000);
      go(1'b0, 1001, 32'h0000_0005, 32'h0000_0014);
      chk({31'h0, move_start}, 32'h0000_0000);
      rd(OFF_STATUS, 32'h0000_0003);
      go(1'b0, -1000, 32'h0000_0005, 32'h0000_0014);
      chk({31'h0, move_start}, 32'h0000_0001);
      lim_p <= 1'b1;
      go(1'b1, 1500, 32'h0000_0005, 32'h0000_0014);
      chk({31'h0, move_start}, 32'h0000_0001);
      @(posedge pclk);
      chk({30'h0, eff_p, eff_n}, 32'h0000_0000);
      settle(3);
      chk({30'h0, eff_p, eff_n}, 32'h0000_0002);
      lim_p <= 1'b0;
      $display("limits done");
   endtask
   task automatic t_defaults;
      logic [31:0] c[4] = '{32'h02, 32'h12, 32'h06, 32'h0A};
      logic signed [31:0] xp[4] = '{480, 20, 500, 3000};
      logic signed [31:0] xn[4] = '{-20, -480, -500, -3000};
      wr(OFF_STROKE, 32'sd500);
      wr(OFF_HOME_OFS, 32'sd20);
      wr(OFF_DRV_MAX, 32'sd3000);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_CTRL, c[i]);
         rd(OFF_SW_POS, xp[i]);
         rd(OFF_SW_NEG, xn[i]);
      end
      $display("defaults done");
   endtask
   task automatic t_current;
      wr(OFF_PEAK_CUR, 32'h0000_03E8);
      wr(OFF_CONT_CUR, 32'h0000_03E8);
      wr(OFF_HOLD_PCT, 32'h0000_0019);
      go(1'b0, 80, 32'h0000_0005, 32'h0000_0014);
      repeat (3) @(posedge pclk);
      chk({16'h0, current_limit}, 32'h0000_01F4);
      settle(4);
      chk({16'h0, current_limit}, 32'h0000_00FA);
      $display("current done");
   endtask
   task automatic t_eco;
      wr(OFF_INPOS, 32'h0000_0005);
      wr(OFF_PERR, 32'h0000_0032);
      wr(OFF_CTRL, 32'h0000_0001);
      repeat (4) @(posedge pclk);
      chk({31'h0, loop_hold}, 32'h0000_0001);
      push <= 32'sd50;
      repeat (4) @(posedge pclk);
      chk({31'h0, loop_hold}, 32'h0000_0000);
      chk({24'h0, loop_gain_pct}, 32'h0000_0064);
      push <= 32'sh0000_0000;
      go(1'b0, 200, 32'h0000_0005, 32'h0000_0014);
      push <= 32'sd60;
      repeat (4) @(posedge pclk);
      chk({31'h0, pos_err_fault}, 32'h0000_0001);
      push <= 32'sh0000_0000;
      fault_stop <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(move_acc, 32'h0000_0064);
      fault_stop <= 1'b0;
      settle(2);
      $display("eco done");
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, lim_p, lim_n, fault_stop, paddr, pwdata,
         push} = '0;
      cmd = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_zone();
      t_clamp();
      t_limits();
      t_defaults();
      t_current();
      t_eco();
      results();
   end
   initial begin
      #500us;
      fails++;
      results();
   end
endmodule
`default_nettype wire
